//--- rtl/breaker_fail_pkg.sv
package breaker_fail_pkg;

  // Scaling of settings and measurements
  localparam int unsigned MAG_W          = 16; // Magnitude, 0.001 x In units
  localparam int unsigned PH_THR_W       = 12; // Phase threshold, 0.01 x In
  localparam int unsigned RES_THR_W      = 16; // Residual thr, 0.001 x In
  localparam int unsigned DLY_W          = 19; // Delay in 5 ms steps
  localparam int unsigned CMP_W          = 24; // Width of scaled compares
  localparam logic [3:0]  PH_TO_MAG      = 4'ha;  // 0.01 In -> 0.001 In
  localparam logic [6:0]  PCT_FULL       = 7'h64; // 100 percent
  localparam logic [6:0]  PCT_RELEASE    = 7'h61; // 97 percent drop-out

  // Time base of the delay settings
  localparam int unsigned DLY_STEP_US    = 5000; // One delay step, 5 ms

  // Values after reset
  localparam logic [PH_THR_W-1:0]  PH_THR_RST  = 12'h014;  // 0.20 x In
  localparam logic [RES_THR_W-1:0] RES_THR_RST = 16'h04b0; // 1.200 x In
  localparam logic [DLY_W-1:0]     RETRIP_RST  = 19'h00014; // 0.100 s
  localparam logic [DLY_W-1:0]     BF_DLY_RST  = 19'h00028; // 0.200 s
  localparam logic                 RETRIP_EN_RST = 1'b1;

  // Residual current source
  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_ONE  = 2'h1,
    RES_TWO  = 2'h2,
    RES_CALC = 2'h3
  } res_src_t;

  // Trigger criteria combinations
  typedef enum logic [3:0] {
    MODE_CUR            = 4'h0,
    MODE_DO             = 4'h1,
    MODE_SIG            = 4'h2,
    MODE_CUR_AND_DO     = 4'h3,
    MODE_CUR_OR_DO      = 4'h4,
    MODE_CUR_AND_SIG    = 4'h5,
    MODE_CUR_OR_SIG     = 4'h6,
    MODE_SIG_AND_DO     = 4'h7,
    MODE_SIG_OR_DO      = 4'h8,
    MODE_CUR_AND_SIG_DO = 4'h9,
    MODE_CUR_OR_SIG_DO  = 4'ha
  } op_mode_t;

  // Reported function condition
  typedef enum logic [2:0] {
    COND_NORMAL  = 3'h0,
    COND_START   = 3'h1,
    COND_RETRIP  = 3'h2,
    COND_BF      = 3'h3,
    COND_ON      = 3'h4,
    COND_BLOCKED = 3'h5
  } cond_t;

  // Logical node mode and behaviour
  typedef enum logic [2:0] {
    LN_ON       = 3'h0,
    LN_BLOCKED  = 3'h1,
    LN_TEST     = 3'h2,
    LN_TEST_BLK = 3'h3,
    LN_OFF      = 3'h4
  } ln_mode_t;

  // Forced status values
  typedef enum logic [2:0] {
    FORCE_NORMAL  = 3'h0,
    FORCE_START   = 3'h1,
    FORCE_RETRIP  = 3'h2,
    FORCE_BF      = 3'h3,
    FORCE_BLOCKED = 3'h4
  } force_t;

  // Pick-up sequence, codes in Gray order; IDLE and BLOCKED differ in both bits
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_START   = 2'b01,
    ST_BLOCKED = 2'b11
  } seq_state_t;

endpackage

//--- rtl/breaker_fail_supervisor.sv
`timescale 1ns/1ps
module breaker_fail_supervisor
  import breaker_fail_pkg::*;
#(
  parameter int unsigned CYCLE_US = 5000, // Program cycle period
  parameter int unsigned TIMER_W  = 24
) (
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  // Program cycle tick and measurements
  input  wire logic                 i_cycle_tick,
  input  wire logic [MAG_W-1:0]     i_phase_a_mag,
  input  wire logic [MAG_W-1:0]     i_phase_b_mag,
  input  wire logic [MAG_W-1:0]     i_phase_c_mag,
  input  wire logic [MAG_W-1:0]     i_residual_input_one,
  input  wire logic [MAG_W-1:0]     i_residual_input_two,
  input  wire logic [MAG_W-1:0]     i_computed_residual,
  // Trigger sources and blocking
  input  wire logic                 i_trip_signal,
  input  wire logic                 i_output_monitor,
  input  wire logic                 i_block,
  // Settings
  input  wire logic [1:0]           i_residual_source_select,
  input  wire logic [3:0]           i_op_mode,
  input  wire logic [PH_THR_W-1:0]  i_phase_thr,
  input  wire logic [RES_THR_W-1:0] i_residual_thr,
  input  wire logic                 i_retrip_enable,
  input  wire logic [DLY_W-1:0]     i_repeat_trip_delay,
  input  wire logic [DLY_W-1:0]     i_bf_delay,
  input  wire logic [2:0]           i_ln_mode,
  input  wire logic                 i_force_enable,
  input  wire logic [2:0]           i_force_status,
  // Outputs
  output logic                      o_current_pickup,
  output logic                      o_start,
  output logic                      o_blocked,
  output logic                      o_retrip,
  output logic                      o_breaker_fail_trip,
  output logic [2:0]                o_condition,
  output logic [2:0]                o_behaviour
);

  localparam int unsigned STEP_TICKS_I =
    (DLY_STEP_US / CYCLE_US) < 1 ? 1 : (DLY_STEP_US / CYCLE_US);
  localparam logic [TIMER_W-1:0] STEP_TICKS = TIMER_W'(STEP_TICKS_I);

  seq_state_t         st_q, st_d;
  logic               cur_q, cur_d;
  logic [TIMER_W-1:0] cnt_q, cnt_d;
  logic               start_q, blocked_q, retrip_q, bf_q;
  logic [2:0]         cond_q, cond_d, beh_q;

  // Phase compares with hysteresis, scaled to common units
  wire [CMP_W-1:0] ph_thr_s  =
    CMP_W'(i_phase_thr) * CMP_W'(PH_TO_MAG);
  wire [CMP_W-1:0] ph_rel_s  = ph_thr_s * CMP_W'(PCT_RELEASE);
  wire [CMP_W-1:0] res_rel_s = CMP_W'(i_residual_thr) * CMP_W'(PCT_RELEASE);
  wire [CMP_W-1:0] a_pct     = CMP_W'(i_phase_a_mag) * CMP_W'(PCT_FULL);
  wire [CMP_W-1:0] b_pct     = CMP_W'(i_phase_b_mag) * CMP_W'(PCT_FULL);
  wire [CMP_W-1:0] c_pct     = CMP_W'(i_phase_c_mag) * CMP_W'(PCT_FULL);
  wire ph_over  = (CMP_W'(i_phase_a_mag) > ph_thr_s) |
                  (CMP_W'(i_phase_b_mag) > ph_thr_s) |
                  (CMP_W'(i_phase_c_mag) > ph_thr_s);
  wire ph_below = (a_pct < ph_rel_s) & (b_pct < ph_rel_s) &
                  (c_pct < ph_rel_s);

  // Residual source selection
  wire res_used = i_residual_source_select != RES_NONE;
  wire [MAG_W-1:0] res_mag =
    (i_residual_source_select == RES_ONE) ? i_residual_input_one :
    (i_residual_source_select == RES_TWO) ? i_residual_input_two :
    i_computed_residual;
  wire [CMP_W-1:0] res_pct = CMP_W'(res_mag) * CMP_W'(PCT_FULL);
  wire res_over  = res_used & (res_mag > i_residual_thr);
  wire res_below = !res_used | (res_pct < res_rel_s);

  // Current pick-up with release only when everything is below
  wire cur_over  = ph_over | res_over;
  wire cur_below = ph_below & res_below;
  assign cur_d = cur_over ? 1'b1 : (cur_below ? 1'b0 : cur_q);

  // Operating mode decode
  op_mode_t mode;
  assign mode = op_mode_t'(i_op_mode);
  wire use_cur = mode inside {MODE_CUR, MODE_CUR_AND_DO, MODE_CUR_OR_DO,
                 MODE_CUR_AND_SIG, MODE_CUR_OR_SIG, MODE_CUR_AND_SIG_DO,
                 MODE_CUR_OR_SIG_DO};
  wire use_do  = mode inside {MODE_DO, MODE_CUR_AND_DO, MODE_CUR_OR_DO,
                 MODE_SIG_AND_DO, MODE_SIG_OR_DO, MODE_CUR_AND_SIG_DO,
                 MODE_CUR_OR_SIG_DO};
  wire use_sig = mode inside {MODE_SIG, MODE_CUR_AND_SIG, MODE_CUR_OR_SIG,
                 MODE_SIG_AND_DO, MODE_SIG_OR_DO, MODE_CUR_AND_SIG_DO,
                 MODE_CUR_OR_SIG_DO};
  wire is_and  = mode inside {MODE_CUR_AND_DO, MODE_CUR_AND_SIG,
                 MODE_SIG_AND_DO, MODE_CUR_AND_SIG_DO};
  wire and_all = (!use_cur | cur_d) & (!use_do | i_output_monitor) &
                 (!use_sig | i_trip_signal);
  wire or_any  = (use_cur & cur_d) | (use_do & i_output_monitor) |
                 (use_sig & i_trip_signal);
  // AND with current: current picks up, the rest lets timers run
  wire pickup  = is_and ? (use_cur ? cur_d : and_all) : or_any;
  wire run     = is_and ? and_all : or_any;

  // Logical node mode and sampled blocking
  wire ln_off  = i_ln_mode == LN_OFF;
  wire eff_blk = i_block | (i_ln_mode == LN_BLOCKED) |
                 (i_ln_mode == LN_TEST_BLK);

  // Pick-up sequence
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (pickup && !eff_blk) begin
          st_d = ST_START;
        end else if (pickup) begin
          st_d = ST_BLOCKED;
        end
      end
      ST_START: begin
        if (!pickup) begin
          st_d = ST_IDLE;
        end else if (eff_blk) begin
          st_d = ST_BLOCKED;
        end
      end
      ST_BLOCKED: begin
        if (!pickup) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (ln_off) begin
      st_d = ST_IDLE;
    end
  end

  // Shared delay timer, in program cycle ticks
  wire timing = (st_d == ST_START) & run;
  wire [TIMER_W-1:0] cnt_inc = (cnt_q == {TIMER_W{1'b1}}) ? cnt_q :
                               cnt_q + TIMER_W'(1);
  assign cnt_d = timing ? cnt_inc : '0;
  wire [TIMER_W-1:0] rt_ticks =
    TIMER_W'(TIMER_W'(i_repeat_trip_delay) * STEP_TICKS);
  wire [TIMER_W-1:0] bf_ticks =
    TIMER_W'(TIMER_W'(i_bf_delay) * STEP_TICKS);
  wire rt_hit = timing & (cnt_d >= rt_ticks) & i_retrip_enable;
  wire bf_hit = timing & (cnt_d >= bf_ticks);

  // Output values, optionally forced
  wire     frc = i_force_enable;
  force_t  fst;
  assign fst = force_t'(i_force_status);
  wire start_d   = frc ? (fst == FORCE_START) : (st_d == ST_START);
  wire blocked_d = frc ? (fst == FORCE_BLOCKED) :
                         (st_d == ST_BLOCKED);
  wire retrip_d  = i_retrip_enable &
                   (frc ? (fst == FORCE_RETRIP) : rt_hit);
  wire bf_d      = frc ? (fst == FORCE_BF) : bf_hit;

  // Condition report, most severe first
  always_comb begin
    if (frc) begin
      case (fst)
        FORCE_START:   cond_d = COND_START;
        FORCE_RETRIP:  cond_d = COND_RETRIP;
        FORCE_BF:      cond_d = COND_BF;
        FORCE_BLOCKED: cond_d = COND_BLOCKED;
        default:       cond_d = COND_NORMAL;
      endcase
    end else if (blocked_d) begin
      cond_d = COND_BLOCKED;
    end else if (bf_d) begin
      cond_d = COND_BF;
    end else if (retrip_d) begin
      cond_d = COND_RETRIP;
    end else if (start_d && run) begin
      cond_d = COND_START;
    end else if (start_d) begin
      cond_d = COND_ON; // Picked up, timers held
    end else begin
      cond_d = COND_NORMAL;
    end
  end

  // State and outputs advance once per program cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q      <= ST_IDLE;
      cur_q     <= 1'b0;
      cnt_q     <= '0;
      start_q   <= 1'b0;
      blocked_q <= 1'b0;
      retrip_q  <= 1'b0;
      bf_q      <= 1'b0;
      cond_q    <= COND_NORMAL;
      beh_q     <= LN_ON;
    end else if (i_cycle_tick) begin
      st_q      <= st_d;
      cur_q     <= cur_d;
      cnt_q     <= cnt_d;
      start_q   <= start_d;
      blocked_q <= blocked_d;
      retrip_q  <= retrip_d;
      bf_q      <= bf_d;
      cond_q    <= cond_d;
      beh_q     <= i_ln_mode;
    end
  end

  assign o_current_pickup    = cur_q;
  assign o_start             = start_q;
  assign o_blocked           = blocked_q;
  assign o_retrip            = retrip_q;
  assign o_breaker_fail_trip = bf_q;
  assign o_condition         = cond_q;
  assign o_behaviour         = beh_q;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_start_on_pickup: assert property (
    i_cycle_tick && st_q == ST_IDLE && pickup && !eff_blk && !ln_off &&
    !frc |=> o_start && !o_blocked && cnt_q <= 1)
    else $error("start not raised on unblocked pick-up");
  a_blocked_pickup: assert property (
    i_cycle_tick && st_q == ST_IDLE && pickup && eff_blk && !ln_off &&
    !frc |=> o_blocked && !o_start && cnt_q == 0)
    else $error("blocked pick-up not reported");
  a_block_clears_start: assert property (
    i_cycle_tick && st_q == ST_START && pickup && eff_blk && !ln_off &&
    !frc |=> !o_start && cnt_q == 0 && !o_retrip && !o_breaker_fail_trip)
    else $error("blocking did not clear start");
  a_retrip_delay: assert property (
    i_cycle_tick && !frc && timing && i_retrip_enable |=>
    o_retrip == (cnt_q >= $past(rt_ticks)))
    else $error("retrip timing wrong");
  a_bf_delay: assert property (
    i_cycle_tick && !frc && timing |=>
    o_breaker_fail_trip == (cnt_q >= $past(bf_ticks)))
    else $error("breaker-fail timing wrong");
  a_retrip_absent: assert property (
    i_cycle_tick && !i_retrip_enable |=> !o_retrip)
    else $error("retrip with retrip disabled");
  a_timer_clears: assert property (
    i_cycle_tick && !timing |=> cnt_q == 0)
    else $error("timer not cleared on release");
  a_hold_between: assert property (
    !i_cycle_tick |=> $stable(o_start) && $stable(o_blocked) &&
    $stable(cnt_q))
    else $error("state moved between ticks");
  a_hyst_hold: assert property (
    i_cycle_tick && cur_q && !cur_over && !cur_below |=> o_current_pickup)
    else $error("pick-up dropped inside hysteresis");
  a_force_override: assert property (
    i_cycle_tick && frc && fst == FORCE_BLOCKED |=>
    o_blocked && o_condition == COND_BLOCKED && !o_start)
    else $error("forced blocked not shown");

  // Pick-up, mode and status checks
  a_pickup_sets: assert property (
    i_cycle_tick && ph_over |=> o_current_pickup)
    else $error("pick-up missed above threshold");
  a_and_halts: assert property (
    i_cycle_tick && !frc && is_and && use_cur && cur_d && !and_all |=>
    cnt_q == 0 && !o_retrip && !o_breaker_fail_trip)
    else $error("timers ran with AND criteria incomplete");
  a_or_keeps_timing: assert property (
    i_cycle_tick && !frc && !is_and && st_q == ST_START && or_any &&
    !eff_blk && !ln_off |=> o_start && cnt_q != 0)
    else $error("OR mode timer cleared while a criterion held");
  a_blocked_holds: assert property (
    i_cycle_tick && !frc && st_d == ST_BLOCKED |=>
    o_blocked && !o_start && cnt_q == 0)
    else $error("blocked state went on processing");
  a_behaviour_copy: assert property (
    i_cycle_tick |=> o_behaviour == $past(i_ln_mode))
    else $error("behaviour not reported");

  c_retrip: cover property (o_retrip ##1 o_breaker_fail_trip);
  c_blocked: cover property ($rose(o_blocked));
  c_start_release: cover property ($fell(o_start) && !o_blocked);
  c_timers_held: cover property (o_start && o_condition == COND_ON);

endmodule

//--- tb/protection_side.sv
`timescale 1ns/1ps
module protection_side #(
  parameter int unsigned RELAY_LAG = 3 // Contact closing lag, min 2
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // Commands from the bench
  input  wire logic i_cmd_trip,
  input  wire logic i_cmd_relay,
  // Criteria seen by the supervisor
  output logic      o_trip_signal,
  output logic      o_output_monitor
);
  logic [RELAY_LAG-1:0] relay_q;

  // Trip one cycle late, contact slower as a real relay
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trip_signal <= 1'b0;
      relay_q       <= '0;
    end else begin
      o_trip_signal <= i_cmd_trip;
      relay_q       <= {relay_q[RELAY_LAG-2:0], i_cmd_relay};
    end
  end
  assign o_output_monitor = relay_q[RELAY_LAG-1];
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import breaker_fail_pkg::*;
  // Bench signals
  logic                 clk, rst_n, tick, blk, rt_en, frc_en;
  logic [MAG_W-1:0]     ph_a, ph_b, ph_c, r_one, r_two, r_calc;
  logic                 cmd_trip, cmd_relay, trip_sig, relay_mon;
  logic [1:0]           res_sel;
  logic [3:0]           mode;
  logic [DLY_W-1:0]     rt_dly, bf_dly;
  logic [PH_THR_W-1:0]  ph_thr;
  logic [2:0]           ln, frc, cond, behav;
  logic                 pick, start, blocked, retrip, bf;
  int                   err_count = 0;
  int                   tests_run = 0;
  int                   cyc = 0;
  logic [11:0]          mode_exp = 12'h55b; // Retrip per mode, cur+DO on
  logic [2:0]           frc_exp [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};

  breaker_fail_supervisor DUT (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_cycle_tick(tick),
    .i_phase_a_mag(ph_a), .i_phase_b_mag(ph_b), .i_phase_c_mag(ph_c),
    .i_residual_input_one(r_one), .i_residual_input_two(r_two),
    .i_computed_residual(r_calc), .i_trip_signal(trip_sig),
    .i_output_monitor(relay_mon), .i_block(blk),
    .i_residual_source_select(res_sel), .i_op_mode(mode),
    .i_phase_thr(ph_thr), .i_residual_thr(RES_THR_RST),
    .i_retrip_enable(rt_en), .i_repeat_trip_delay(rt_dly),
    .i_bf_delay(bf_dly), .i_ln_mode(ln), .i_force_enable(frc_en),
    .i_force_status(frc), .o_current_pickup(pick), .o_start(start),
    .o_blocked(blocked), .o_retrip(retrip),
    .o_breaker_fail_trip(bf), .o_condition(cond), .o_behaviour(behav));

  protection_side side (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd_trip(cmd_trip),
    .i_cmd_relay(cmd_relay), .o_trip_signal(trip_sig),
    .o_output_monitor(relay_mon));

  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  // Program cycles: tick high one cycle, low one cycle
  task automatic step(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_fld(input string nm, input logic [2:0] e,
                         input logic [2:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0; rst_n = 1'b0; tick = 1'b0; blk = 1'b0; frc_en = 1'b0;
    rt_en = RETRIP_EN_RST; rt_dly = RETRIP_RST; bf_dly = BF_DLY_RST;
    ph_a = '0; ph_b = '0; ph_c = '0; r_one = '0; r_two = '0; r_calc = '0;
    cmd_trip = 1'b0; cmd_relay = 1'b0; res_sel = RES_NONE;
    mode = MODE_CUR; ln = LN_ON; frc = FORCE_NORMAL;
    ph_thr = PH_THR_RST;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_fld("cond", 3'h0, cond);
    ph_b <= 16'h00c8;
    step(1);
    chk_bit("pickup", 1'b0, pick);
    ph_b <= 16'h00c9;
    step(1);
    chk_bit("start", 1'b1, start);
    chk_fld("cond", 3'h1, cond);
    ph_b <= 16'h00c2;
    step(1);
    chk_bit("pickup", 1'b1, pick);
    ph_a <= 16'h012c;
    ph_b <= 16'h00c1;
    step(1);
    chk_bit("pickup", 1'b1, pick);
    ph_a <= '0;
    step(1);
    chk_bit("pickup", 1'b0, pick);
    ph_thr <= 12'h015;
    ph_b <= 16'h00d2;
    step(1);
    chk_bit("pickup", 1'b0, pick);
    ph_b <= 16'h00d3;
    step(1);
    chk_bit("pickup", 1'b1, pick);
    ph_b <= '0;
    ph_thr <= PH_THR_RST;
    step(1);
    chk_bit("pickup", 1'b0, pick);
    $display("test threshold done");
    for (int e = 1; e >= 0; e--) begin
      rt_en <= e[0];
      ph_c <= 16'h012c;
      step(19);
      chk_bit("retrip", 1'b0, retrip);
      step(1);
      chk_bit("retrip", e[0], retrip);
      step(19);
      chk_bit("bf", 1'b0, bf);
      step(1);
      chk_bit("bf", 1'b1, bf);
      chk_fld("cond", 3'h3, cond);
      ph_c <= '0;
      step(1);
      chk_bit("bf", 1'b0, bf);
    end
    $display("test timers done");
    rt_en <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      res_sel <= s[1:0];
      r_one <= (s == 0 || s == 1) ? 16'h04b1 : 16'h04b0;
      r_two <= (s == 0 || s == 2) ? 16'h04b1 : 16'h04b0;
      r_calc <= (s == 0 || s == 3) ? 16'h04b1 : 16'h04b0;
      step(1);
      chk_bit("res pickup", s != 0, pick);
      r_one <= '0; r_two <= '0; r_calc <= '0;
      step(1);
    end
    $display("test residual done");
    rt_dly <= 19'h00003;
    bf_dly <= 19'h00005;
    ph_a <= 16'h012c;
    blk <= 1'b1;
    step(1);
    chk_bit("blocked", 1'b1, blocked);
    chk_bit("start", 1'b0, start);
    chk_fld("cond", 3'h5, cond);
    step(5);
    chk_bit("bf", 1'b0, bf);
    blk <= 1'b0; ph_a <= '0;
    step(1);
    ph_a <= 16'h012c;
    step(1);
    blk <= 1'b1;
    @(posedge clk);
    blk <= 1'b0;
    step(1);
    chk_bit("blocked", 1'b0, blocked);
    blk <= 1'b1;
    step(1);
    chk_bit("start", 1'b0, start);
    chk_bit("retrip", 1'b0, retrip);
    blk <= 1'b0; ph_a <= '0;
    step(1);
    $display("test blocking done");
    for (int m = 0; m < 12; m++) begin
      mode <= m[3:0]; ph_a <= 16'h012c; cmd_relay <= 1'b1;
      step(5);
      chk_bit("mode retrip", mode_exp[m], retrip);
      ph_a <= '0; cmd_relay <= 1'b0;
      step(3);
    end
    mode <= MODE_CUR_AND_DO; ph_a <= 16'h012c;
    step(4);
    chk_fld("cond", 3'h4, cond);
    chk_bit("retrip", 1'b0, retrip);
    cmd_relay <= 1'b1;
    step(5);
    chk_bit("retrip", 1'b1, retrip);
    ph_a <= '0; cmd_relay <= 1'b0; mode <= MODE_CUR_OR_SIG; cmd_trip <= 1'b1;
    step(3);
    ph_a <= 16'h012c;
    step(1);
    ph_a <= '0;
    step(3);
    chk_bit("retrip", 1'b1, retrip);
    cmd_trip <= 1'b0;
    step(2);
    chk_bit("retrip", 1'b0, retrip);
    mode <= MODE_CUR;
    $display("test modes done");
    frc_en <= 1'b1;
    for (int f = 0; f < 5; f++) begin
      frc <= f[2:0];
      step(1);
      chk_fld("forced cond", frc_exp[f], cond);
      chk_bit("forced retrip", f == 2, retrip);
    end
    frc_en <= 1'b0;
    for (int l = 0; l < 5; l++) begin
      ln <= l[2:0];
      step(1);
      chk_fld("behaviour", l[2:0], behav);
    end
    $display("test status done");
    close_out();
  end
endmodule
